/* rtl/dmh_device.sv */
// Purpose: device end of the dual mode host bus pin layer
// Assumes: register core answers reads in the cycle its read pulse is high
// Notes: all bus pins pass two flops; mode input is static between cycles
// Contract
// RL1 - read_not_write_line high reads, low writes
// RL2 - isa write only while write strobe low
// RL3 - byte high enable low marks upper byte
// RL4 - rom read strobe starts a rom read
// RL5 - bale falling edge latches address, byte enable
// RL6 - ready dropped to insert isa wait states
// RL7 - 16-bit select when address matches base
// RL8 - transfer ack asserted when transfer done
// RL9 - one unencoded interrupt in processor mode
// RL10 - isa-only outputs idle in processor mode
`timescale 1ns/1ps
`default_nettype none
module dmh_device
  import dmh_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bus pins
  dmh_bus_if.dev bus,
  // configuration
  input wire logic isa_mode,
  input wire logic [dmh_pkg::BASE_W-1:0] base_addr,
  // register core
  output logic reg_wr,
  output logic reg_rd,
  output logic rom_rd,
  output logic [dmh_pkg::ADDR_W-1:0] reg_addr,
  output logic [dmh_pkg::DATA_W-1:0] reg_wdata,
  output logic reg_hi_en,
  input wire logic [dmh_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [dmh_pkg::DATA_W-1:0] rom_rdata,
  // interrupt sources
  input wire logic [dmh_pkg::IRQ_N-1:0] irq_src
);
  import dmh_pkg::*;

  dmh_pins_t ctl_s1;
  dmh_pins_t ctl_s2;
  logic [15:0] addr_s1;
  logic [15:0] addr_s2;
  logic [15:0] data_s1;
  logic [15:0] data_s2;

  dmh_dev_state_t state;
  dmh_dev_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic [15:0] lat_addr;
  logic [15:0] next_lat_addr;
  logic lat_hi_n;
  logic next_lat_hi_n;
  logic is_read;
  logic next_is_read;
  logic is_rom;
  logic next_is_rom;
  logic bale_prev;
  logic next_bale_prev;
  logic iochrdy;
  logic next_iochrdy;
  logic iocs16_n;
  logic next_iocs16_n;
  logic ack_n;
  logic next_ack_n;
  logic [15:0] dout;
  logic [15:0] next_dout;
  logic doe;
  logic next_doe;
  logic [3:0] irq;
  logic [3:0] next_irq;
  logic next_reg_wr;
  logic next_reg_rd;
  logic next_rom_rd;
  logic [15:0] next_reg_addr;
  logic [15:0] next_reg_wdata;
  logic next_reg_hi_en;

  // pins come from the far side, so two flops before use
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctl_s1 <= PINS_IDLE;
      ctl_s2 <= PINS_IDLE;
      addr_s1 <= DATA_RST;
      addr_s2 <= DATA_RST;
      data_s1 <= DATA_RST;
      data_s2 <= DATA_RST;
    end else begin
      ctl_s1 <= bus.pins;
      ctl_s2 <= ctl_s1;
      addr_s1 <= bus.addr;
      addr_s2 <= addr_s1;
      data_s1 <= bus.data_bus;
      data_s2 <= data_s1;
    end
  end

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_lat_addr = lat_addr;
    next_lat_hi_n = lat_hi_n;
    next_is_read = is_read;
    next_is_rom = is_rom;
    next_bale_prev = ctl_s2.bale;
    next_iochrdy = iochrdy;
    next_ack_n = ack_n;
    next_dout = dout;
    next_doe = doe;
    next_reg_wr = 1'b0;
    next_reg_rd = 1'b0;
    next_rom_rd = 1'b0;
    next_reg_addr = reg_addr;
    next_reg_wdata = reg_wdata;
    next_reg_hi_en = reg_hi_en;
    // live address decode, not gated by aen, so in isa mode the select follows the address alone
    next_iocs16_n = !(isa_mode && dmh_addr_hit(addr_s2, base_addr)); // RL7 RL10
    // processor mode folds every source onto line 0
    next_irq = isa_mode ? irq_src : {3'b000, |irq_src}; // RL9 RL10
    if (isa_mode && bale_prev && !ctl_s2.bale) begin
      next_lat_addr = addr_s2; // RL5
      next_lat_hi_n = ctl_s2.sbhe_n; // RL3
    end
    unique case (state)
      DEV_IDLE: begin
        next_iochrdy = 1'b1;
        next_ack_n = 1'b1;
        next_cnt = 4'h0;
        if (isa_mode) begin
          if (!ctl_s2.memr_n) begin
            next_is_read = 1'b1; // RL4
            next_is_rom = 1'b1;
            next_iochrdy = 1'b0; // RL6
            next_state = DEV_WAIT;
          end else if (!ctl_s2.aen && (!ctl_s2.iord_n || !ctl_s2.iowr_n) && dmh_addr_hit(lat_addr, base_addr)) begin
            next_is_read = !ctl_s2.iord_n;
            next_is_rom = 1'b0;
            next_iochrdy = 1'b0; // RL6
            next_state = DEV_WAIT;
          end
        end else if (!ctl_s2.address_strobe_n && !ctl_s2.data_strobe_in) begin
          // word access only: upper byte always taken
          next_lat_addr = addr_s2;
          next_lat_hi_n = 1'b0;
          next_is_read = ctl_s2.read_not_write_line; // RL1
          next_is_rom = 1'b0;
          next_state = DEV_WAIT;
        end
      end
      DEV_WAIT: begin
        if (cnt == DEV_WAIT_LAST) begin
          next_state = DEV_ISSUE;
        end else begin
          next_cnt = 4'(cnt + 4'h1);
        end
      end
      DEV_ISSUE: begin
        next_reg_addr = lat_addr;
        next_reg_wdata = data_s2;
        next_reg_hi_en = !lat_hi_n; // RL3
        if (is_rom) begin
          next_rom_rd = 1'b1; // RL4
        end else if (is_read) begin
          next_reg_rd = 1'b1; // RL1
        end else begin
          // an isa write whose strobe is already gone is dropped
          next_reg_wr = !isa_mode || !ctl_s2.iowr_n; // RL2 RL1
        end
        next_state = DEV_FETCH;
      end
      DEV_FETCH: begin
        next_doe = is_read;
        next_dout = is_rom ? rom_rdata : reg_rdata;
        next_iochrdy = 1'b1; // RL6
        next_ack_n = isa_mode; // RL8
        next_state = DEV_HOLD;
      end
      DEV_HOLD: begin
        if (isa_mode ? (ctl_s2.iord_n && ctl_s2.iowr_n && ctl_s2.memr_n) : ctl_s2.data_strobe_in) begin
          next_doe = 1'b0;
          next_ack_n = 1'b1; // RL8
          next_state = DEV_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= DEV_IDLE;
      cnt <= 4'h0;
      lat_addr <= DATA_RST;
      lat_hi_n <= 1'b1;
      is_read <= 1'b0;
      is_rom <= 1'b0;
      bale_prev <= 1'b0;
      iochrdy <= 1'b1;
      iocs16_n <= 1'b1;
      ack_n <= 1'b1;
      dout <= DATA_RST;
      doe <= 1'b0;
      irq <= 4'h0;
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      rom_rd <= 1'b0;
      reg_addr <= DATA_RST;
      reg_wdata <= DATA_RST;
      reg_hi_en <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      lat_addr <= next_lat_addr;
      lat_hi_n <= next_lat_hi_n;
      is_read <= next_is_read;
      is_rom <= next_is_rom;
      bale_prev <= next_bale_prev;
      iochrdy <= next_iochrdy;
      iocs16_n <= next_iocs16_n;
      ack_n <= next_ack_n;
      dout <= next_dout;
      doe <= next_doe;
      irq <= next_irq;
      reg_wr <= next_reg_wr;
      reg_rd <= next_reg_rd;
      rom_rd <= next_rom_rd;
      reg_addr <= next_reg_addr;
      reg_wdata <= next_reg_wdata;
      reg_hi_en <= next_reg_hi_en;
    end
  end

  assign bus.dev_data = dout;
  assign bus.dev_data_oe = doe;
  assign bus.iochrdy = iochrdy;
  assign bus.iocs16_n = iocs16_n;
  assign bus.transfer_ack_n = ack_n;
  assign bus.isa_irq_line_0 = irq[0];
  assign bus.isa_irq_line_1 = irq[1];
  assign bus.isa_irq_line_2 = irq[2];
  assign bus.isa_irq_line_3 = irq[3];

endmodule : dmh_device
`default_nettype wire

/* common/dmh_pkg.sv */
// Purpose: shared types and constants for the dual mode host bus pin layer
// Assumes: one 100 MHz clock on both ends
// Notes: pin group order matches the sync vector used by the device end
package dmh_pkg;

  // host driven control pins, both bus modes
  typedef struct packed {
    logic aen;
    logic iord_n;
    logic iowr_n;
    logic sbhe_n;
    logic memr_n;
    logic bale;
    logic address_strobe_n;
    logic data_strobe_in;
    logic read_not_write_line;
  } dmh_pins_t;

  localparam dmh_pins_t PINS_IDLE = 9'h1f7;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int BASE_W = 12;
  localparam int IRQ_N = 4;
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] DATA_FLOAT = 16'hffff;
  // device wait states before the core access
  localparam logic [3:0] DEV_WAIT_LAST = 4'h1;
  // host keeps a strobe this long before trusting ready
  localparam logic [3:0] HOST_STROBE_MIN = 4'h8;

  typedef enum {DEV_IDLE, DEV_WAIT, DEV_ISSUE, DEV_FETCH, DEV_HOLD} dmh_dev_state_t;
  typedef enum {HST_IDLE, HST_ADDR, HST_STROBE, HST_RELEASE} dmh_host_state_t;

  function automatic logic dmh_addr_hit(input logic [15:0] a, input logic [11:0] base);
    return a[15:4] == base;
  endfunction : dmh_addr_hit

endpackage : dmh_pkg

/* common/dmh_bus_if.sv */
// Purpose: pins between the host and the device end
// Assumes: data bus has pull-ups when nobody drives it
// Notes: the shared data wire is resolved here from the two enables
`timescale 1ns/1ps
`default_nettype none
interface dmh_bus_if;
  dmh_pkg::dmh_pins_t pins;
  logic [15:0] addr;
  logic [15:0] host_data;
  logic host_data_oe;
  logic [15:0] dev_data;
  logic dev_data_oe;
  logic [15:0] data_bus;
  logic iochrdy;
  logic iocs16_n;
  logic isa_irq_line_0;
  logic isa_irq_line_1;
  logic isa_irq_line_2;
  logic isa_irq_line_3;
  logic transfer_ack_n;

  // device wins a clash; pull-ups otherwise
  assign data_bus = dev_data_oe ? dev_data : (host_data_oe ? host_data : dmh_pkg::DATA_FLOAT);

  modport dev (
    input pins, addr, data_bus,
    output dev_data, dev_data_oe, iochrdy, iocs16_n, transfer_ack_n,
    output isa_irq_line_0, isa_irq_line_1, isa_irq_line_2, isa_irq_line_3
  );
  modport host (
    output pins, addr, host_data, host_data_oe,
    input data_bus, iochrdy, iocs16_n, transfer_ack_n,
    input isa_irq_line_0, isa_irq_line_1, isa_irq_line_2, isa_irq_line_3
  );
endinterface : dmh_bus_if
`default_nettype wire

/* rtl/dmh_host.sv */
// Purpose: host end, isa bus master or 16-bit processor bus master
// Assumes: one command at a time, device on the same board
// Notes: a processor cycle with no device answer never ends
`timescale 1ns/1ps
`default_nettype none
module dmh_host
  import dmh_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bus pins
  dmh_bus_if.host bus,
  // mode
  input wire logic isa_mode,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_write,
  input wire logic cmd_rom,
  input wire logic [dmh_pkg::ADDR_W-1:0] cmd_addr,
  input wire logic [dmh_pkg::DATA_W-1:0] cmd_wdata,
  input wire logic cmd_hi_en,
  // answer
  output logic done,
  output logic [dmh_pkg::DATA_W-1:0] rdata,
  output logic [dmh_pkg::IRQ_N-1:0] irq_lines,
  output logic wide_sel
);
  import dmh_pkg::*;

  logic [7:0] in_s1;
  logic [7:0] in_s2;
  logic [15:0] data_s1;
  logic [15:0] data_s2;
  logic ready_s;
  logic ack_n_s;

  dmh_host_state_t state;
  dmh_host_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  dmh_pins_t pins;
  dmh_pins_t next_pins;
  logic [15:0] addr;
  logic [15:0] next_addr;
  logic [15:0] hdata;
  logic [15:0] next_hdata;
  logic hoe;
  logic next_hoe;
  logic wr;
  logic next_wr;
  logic rom;
  logic next_rom;
  logic next_cmd_ready;
  logic next_done;
  logic [15:0] next_rdata;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      in_s1 <= 8'h0f;
      in_s2 <= 8'h0f;
      data_s1 <= DATA_RST;
      data_s2 <= DATA_RST;
    end else begin
      in_s1 <= {bus.isa_irq_line_3, bus.isa_irq_line_2, bus.isa_irq_line_1, bus.isa_irq_line_0,
                bus.iochrdy, bus.iocs16_n, bus.transfer_ack_n, 1'b1};
      in_s2 <= in_s1;
      data_s1 <= bus.data_bus;
      data_s2 <= data_s1;
    end
  end

  assign ready_s = in_s2[3];
  assign ack_n_s = in_s2[1];

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_pins = pins;
    next_addr = addr;
    next_hdata = hdata;
    next_hoe = hoe;
    next_wr = wr;
    next_rom = rom;
    next_cmd_ready = cmd_ready;
    next_done = 1'b0;
    next_rdata = rdata;
    unique case (state)
      HST_IDLE: begin
        // park pins per mode: unused processor-side inputs pulled
        next_pins = PINS_IDLE;
        next_pins.sbhe_n = isa_mode; // RL3
        next_pins.bale = !isa_mode; // RL5
        next_cmd_ready = 1'b1;
        next_hoe = 1'b0;
        if (cmd_valid && cmd_ready) begin
          next_cmd_ready = 1'b0;
          next_addr = cmd_addr;
          next_hdata = cmd_wdata;
          next_hoe = cmd_write && !(isa_mode && cmd_rom);
          next_wr = cmd_write;
          next_rom = isa_mode && cmd_rom;
          if (isa_mode) begin
            next_pins.aen = 1'b0;
            next_pins.bale = 1'b1;
            next_pins.sbhe_n = !cmd_hi_en; // RL3
          end else begin
            next_pins.read_not_write_line = !cmd_write; // RL1
            next_pins.address_strobe_n = 1'b0;
          end
          next_state = HST_ADDR;
        end
      end
      HST_ADDR: begin
        // bale falls one cycle ahead of the strobe so the latch is settled
        next_pins.bale = !isa_mode; // RL5
        next_cnt = 4'h0;
        next_state = HST_STROBE;
      end
      HST_STROBE: begin
        if (isa_mode) begin
          next_pins.memr_n = !rom; // RL4
          next_pins.iowr_n = rom || !wr; // RL2
          next_pins.iord_n = rom || wr;
        end else begin
          next_pins.data_strobe_in = 1'b0;
        end
        if (cnt != HOST_STROBE_MIN) begin
          next_cnt = 4'(cnt + 4'h1);
        end else if (isa_mode ? ready_s : !ack_n_s) begin
          // ready held low by the device stretches this state
          next_rdata = data_s2; // RL6 RL8
          next_pins.iord_n = 1'b1;
          next_pins.iowr_n = 1'b1;
          next_pins.memr_n = 1'b1;
          next_pins.data_strobe_in = 1'b1;
          next_pins.address_strobe_n = 1'b1;
          next_hoe = 1'b0;
          next_state = HST_RELEASE;
        end
      end
      HST_RELEASE: begin
        next_pins.aen = 1'b1;
        if (isa_mode || ack_n_s) begin
          next_done = 1'b1;
          next_state = HST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state <= HST_IDLE;
      cnt <= 4'h0;
      pins <= PINS_IDLE;
      addr <= DATA_RST;
      hdata <= DATA_RST;
      hoe <= 1'b0;
      wr <= 1'b0;
      rom <= 1'b0;
      cmd_ready <= 1'b0;
      done <= 1'b0;
      rdata <= DATA_RST;
      irq_lines <= 4'h0;
      wide_sel <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      pins <= next_pins;
      addr <= next_addr;
      hdata <= next_hdata;
      hoe <= next_hoe;
      wr <= next_wr;
      rom <= next_rom;
      cmd_ready <= next_cmd_ready;
      done <= next_done;
      rdata <= next_rdata;
      irq_lines <= in_s2[7:4]; // RL9
      wide_sel <= !in_s2[2]; // RL7
    end
  end

  assign bus.pins = pins;
  assign bus.addr = addr;
  assign bus.host_data = hdata;
  assign bus.host_data_oe = hoe;

endmodule : dmh_host
`default_nettype wire

/* bench/dmh_props.sv */
// Purpose: pin level checks between the host end and the device end
// Assumes: isa_mode only changes while reset is high
// Notes: latencies are bounded loosely, since the sync depth is internal
`timescale 1ns/1ps
`default_nettype none
module dmh_props
  import dmh_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // bus signals
  input wire dmh_pkg::dmh_pins_t pins,
  input wire logic [15:0] addr,
  input wire logic dev_data_oe,
  input wire logic iochrdy,
  input wire logic iocs16_n,
  input wire logic transfer_ack_n,
  input wire logic isa_irq_line_0,
  input wire logic isa_irq_line_1,
  input wire logic isa_irq_line_2,
  input wire logic isa_irq_line_3,
  // device configuration
  input wire logic isa_mode,
  input wire logic [dmh_pkg::BASE_W-1:0] base_addr,
  input wire logic [dmh_pkg::IRQ_N-1:0] irq_src
);
  import dmh_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_proc_strobe;
    !pins.address_strobe_n && !pins.data_strobe_in;
  endsequence
  sequence s_addr_steady;
    (isa_mode && $stable(addr) && $stable(base_addr))[*5];
  endsequence

  a_proc_isa_idle: assert property (!isa_mode |-> iochrdy && iocs16_n)
    else $error("isa-only output active in processor mode");
  a_cs16_match: assert property (s_addr_steady |-> iocs16_n == (addr[15:4] != base_addr))
    else $error("16-bit select disagrees with address decode");
  a_ack_cause: assert property ($fell(transfer_ack_n) |-> !isa_mode ##0 s_proc_strobe)
    else $error("ack without processor strobes");
  a_ack_hold: assert property (!transfer_ack_n && !pins.data_strobe_in |=> !transfer_ack_n)
    else $error("ack dropped while strobe still low");
  a_wait_cause: assert property ($fell(iochrdy) |-> isa_mode && !(pins.iord_n && pins.iowr_n && pins.memr_n))
    else $error("wait state outside an isa strobe");
  a_ready_bound: assert property ($fell(iochrdy) |-> ##[1:8] iochrdy)
    else $error("ready held low too long");
  a_oe_dir: assert property ($rose(dev_data_oe) |-> (isa_mode ? !(pins.iord_n && pins.memr_n)
      : pins.read_not_write_line))
    else $error("data driven in a write cycle");
  a_irq_single: assert property ((!isa_mode && $stable(irq_src))[*5] |-> isa_irq_line_0 == (|irq_src)
      && !isa_irq_line_1 && !isa_irq_line_2 && !isa_irq_line_3)
    else $error("processor interrupt not the or of sources");
endmodule : dmh_props
`default_nettype wire

/* bench/test_dual_mode_host_bus_pins.sv */
// Purpose: both ends joined, isa then processor mode traffic
// Assumes: register core answers from levels set before each command
// Notes: mode changes only under reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED at %0t: got %h exp %h", $time, a, b); end end
module test_dual_mode_host_bus_pins;
  import dmh_pkg::*;
  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic isa_mode = 1'b1;
  logic [11:0] base_addr = 12'h030;
  logic cmd_valid = 1'b0, cmd_write = 1'b0, cmd_rom = 1'b0, cmd_hi_en = 1'b0;
  logic [15:0] cmd_addr = 16'h0000, cmd_wdata = 16'h0000;
  logic [15:0] reg_rdata = 16'h5a3c, rom_rdata = 16'hc3a5;
  logic [3:0] irq_src = 4'h0;
  logic cmd_ready, done, wide_sel, reg_wr, reg_rd, rom_rd, reg_hi_en;
  logic [15:0] rdata, reg_addr, reg_wdata;
  logic [3:0] irq_lines;
  logic [15:0] wr_addr, wr_data;
  logic wr_hi;
  int err_count = 0, checks = 0, wr_n = 0, rd_n = 0, rom_n = 0;

  always #5 ref_clk = ~ref_clk;

  dmh_bus_if bus ();
  dmh_device i_dmh_device (.ref_clk(ref_clk), .reset(reset), .bus(bus), .isa_mode(isa_mode),
    .base_addr(base_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .rom_rd(rom_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_hi_en(reg_hi_en), .reg_rdata(reg_rdata), .rom_rdata(rom_rdata),
    .irq_src(irq_src));
  dmh_host i_dmh_host (.ref_clk(ref_clk), .reset(reset), .bus(bus), .isa_mode(isa_mode),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_write(cmd_write), .cmd_rom(cmd_rom),
    .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata), .cmd_hi_en(cmd_hi_en), .done(done), .rdata(rdata),
    .irq_lines(irq_lines), .wide_sel(wide_sel));
  dmh_props i_dmh_props (.ref_clk(ref_clk), .reset(reset), .pins(bus.pins), .addr(bus.addr),
    .dev_data_oe(bus.dev_data_oe), .iochrdy(bus.iochrdy), .iocs16_n(bus.iocs16_n),
    .transfer_ack_n(bus.transfer_ack_n), .isa_irq_line_0(bus.isa_irq_line_0),
    .isa_irq_line_1(bus.isa_irq_line_1), .isa_irq_line_2(bus.isa_irq_line_2),
    .isa_irq_line_3(bus.isa_irq_line_3), .isa_mode(isa_mode), .base_addr(base_addr), .irq_src(irq_src));

  // register core side, counted at each pulse
  always @(posedge ref_clk) begin
    if (reg_wr === 1'b1) begin
      wr_n++;
      wr_addr = reg_addr;
      wr_data = reg_wdata;
      wr_hi = reg_hi_en;
    end
    if (reg_rd === 1'b1) rd_n++;
    if (rom_rd === 1'b1) rom_n++;
  end

  task automatic complete_run;
    $display("errors %0d, checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task automatic do_reset(input logic mode);
    reset <= 1'b1;
    isa_mode <= mode;
    repeat (10) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask : do_reset

  // one host command; held until taken, then waits for done
  task automatic bus_op(input logic w, input logic rom, input logic hi, input logic [15:0] a,
      input logic [15:0] d, output logic [15:0] q);
    int n;
    n = 0;
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_rom <= rom;
    cmd_hi_en <= hi;
    cmd_addr <= a;
    cmd_wdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cmd_ready !== 1'b1 && n < 50);
    cmd_valid <= 1'b0;
    if (n >= 50) err_count++;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (done !== 1'b1 && n < 300);
    if (n >= 300) err_count++;
    q = rdata;
  endtask : bus_op

  // lines are synchronised, so allow a short settle
  task automatic irq_chk(input logic [3:0] src, input logic [3:0] exp);
    int n;
    n = 0;
    irq_src <= src;
    do begin
      @(posedge ref_clk);
      n++;
    end while (irq_lines !== exp && n < 12);
    `CHK(irq_lines, exp)
  endtask : irq_chk

  initial begin
    logic [15:0] q;
    do_reset(1'b1);
    bus_op(1'b1, 1'b0, 1'b1, 16'h0304, 16'h1234, q);
    `CHK(wr_n, 1)
    `CHK(wr_addr, 16'h0304)
    `CHK(wr_data, 16'h1234)
    `CHK(wr_hi, 1'b1)
    `CHK(wide_sel, 1'b1)
    bus_op(1'b1, 1'b0, 1'b0, 16'h0306, 16'h00a5, q);
    `CHK(wr_hi, 1'b0)
    bus_op(1'b0, 1'b0, 1'b1, 16'h0308, 16'h0000, q);
    `CHK(q, 16'h5a3c)
    `CHK(rd_n, 1)
    `CHK(wr_n, 2)
    bus_op(1'b0, 1'b1, 1'b1, 16'h8000, 16'h0000, q);
    `CHK(q, 16'hc3a5)
    `CHK(rom_n, 1)
    bus_op(1'b0, 1'b0, 1'b1, 16'h1230, 16'h0000, q);
    `CHK(q, 16'hffff)
    `CHK(rd_n, 1)
    `CHK(wide_sel, 1'b0)
    irq_chk(4'b1010, 4'b1010);
    irq_chk(4'b0000, 4'b0000);
    do_reset(1'b0);
    reg_rdata <= 16'h0f1e;
    bus_op(1'b1, 1'b0, 1'b0, 16'h0040, 16'hbeef, q);
    `CHK(wr_n, 3)
    `CHK(wr_data, 16'hbeef)
    `CHK(wr_hi, 1'b1)
    `CHK(wr_addr, 16'h0040)
    bus_op(1'b0, 1'b0, 1'b0, 16'h0306, 16'h0000, q);
    `CHK(q, 16'h0f1e)
    `CHK(rd_n, 2)
    `CHK(wide_sel, 1'b0)
    irq_chk(4'b0100, 4'b0001);
    irq_chk(4'b1001, 4'b0001);
    irq_chk(4'b0000, 4'b0000);
    complete_run();
  end

  // whole run is a few hundred cycles; this is far beyond it
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_count++;
    complete_run();
  end
endmodule : test_dual_mode_host_bus_pins
`default_nettype wire
